// *** olm_pkg.sv ***
// Shared constants and types for the OR / load / move execute group.
// Assumes a core that runs one instruction cycle as four system clocks.
package olm_pkg;

	// Instruction cycle phases, one clock each
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} olm_phase_t;

	// Operation held for the current instruction
	typedef enum logic [5:0] {
		OP_NONE = 6'h01,
		OP_OR_LIT = 6'h02,
		OP_OR_FILE = 6'h04,
		OP_COPY_DEST = 6'h08,
		OP_LOAD_PTR = 6'h10,
		OP_FILE_TO_FILE = 6'h20
	} olm_op_t;

	// Opcode fields
	localparam logic [7:0] OPC_OR_LIT = 8'h09;       // Bits 15:8
	localparam logic [5:0] OPC_OR_FILE = 6'h04;      // Bits 15:10
	localparam logic [5:0] OPC_COPY_DEST = 6'h14;    // Bits 15:10
	localparam logic [9:0] OPC_LOAD_PTR = 10'h3b8;   // Bits 15:6
	localparam logic [3:0] OPC_FILE_TO_FILE = 4'hc;  // Bits 15:12
	localparam logic [3:0] OPC_SECOND_WORD = 4'hf;   // Bits 15:12
	localparam int D_BIT = 9;
	localparam int A_BIT = 8;
	localparam logic DEST_ACC = 1'b0;
	localparam logic ACCESS_BANK = 1'b0;

	// Address map
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [11:0] ACC_ADDR = 12'hfe8;
	localparam logic [11:0] PC_LOW_ADDR = 12'hff9;
	localparam logic [11:0] STACK_TOP_LOW_ADDR = 12'hffd;
	localparam logic [11:0] STACK_TOP_HIGH_ADDR = 12'hffe;
	localparam logic [11:0] STACK_TOP_UPPER_ADDR = 12'hfff;

	// Pointers and reset values
	localparam int NUM_PTR = 3;
	localparam int INDEX_PTR = 2;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [11:0] PTR_RST = 12'h000;
	localparam logic [11:0] ADDR_RST = 12'h000;

endpackage

// *** olm_addr_if.sv ***
// Signals between the executer and its file address resolver.
// Purely combinational; no clock travels on it.
`timescale 1ns/100ps
`default_nettype none
interface olm_addr_if;
	logic [7:0] fileAddr;
	logic accessBit;
	logic [3:0] bankSel;
	logic extEnable;
	logic [11:0] indexBase;
	logic [11:0] dataAddr;
	logic indexed;
	modport requester(output fileAddr, output accessBit, output bankSel, output extEnable,
		output indexBase, input dataAddr, input indexed);
	modport resolver(input fileAddr, input accessBit, input bankSel, input extEnable,
		input indexBase, output dataAddr, output indexed);
endinterface
`default_nettype wire

// *** olm_addr_resolve.sv ***
// Turns an 8-bit file operand into a 12-bit data space address.
// Assumes the bank select value and pointer base are stable during the cycle.
`timescale 1ns/100ps
`default_nettype none
module olm_addr_resolve (
	// Address request and answer
	olm_addr_if.resolver bus
);

	// Indexed, access bank or selected bank
	always_comb begin
		bus.indexed = bus.extEnable && (bus.accessBit == olm_pkg::ACCESS_BANK) &&
			(bus.fileAddr <= olm_pkg::INDEXED_LIMIT);
		if (bus.indexed) begin
			bus.dataAddr = bus.indexBase + {4'h0, bus.fileAddr}; // Offset from pointer
		end else if (bus.accessBit == olm_pkg::ACCESS_BANK) begin
			bus.dataAddr = (bus.fileAddr < olm_pkg::ACCESS_SPLIT) ? {4'h0, bus.fileAddr} :
				{olm_pkg::ACCESS_HIGH_BANK, bus.fileAddr};
		end else begin
			bus.dataAddr = {bus.bankSel, bus.fileAddr}; // Any byte of the bank
		end
	end

endmodule
`default_nettype wire

// *** olm_exec.sv ***
// Execute unit for OR-literal, OR-file, load-pointer, copy-file and file-to-file.
// Assumes one instruction cycle of four clocks and a data memory that answers
// a read combinationally in the clock its read enable is high.
`timescale 1ns/100ps
`default_nettype none
module olm_exec (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Instruction word, taken in phase 1
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	// Configuration
	input wire logic [3:0] bankSel,
	input wire logic extEnable,
	// Data memory
	output logic [11:0] dmAddr_r,
	output logic dmRdEn_r,
	input wire logic [7:0] dmRdData,
	output logic dmWrEn_r,
	output logic [7:0] dmWrData_r,
	// Core state
	output logic [7:0] acc_r,
	output logic flagN_r,
	output logic flagZ_r,
	output logic [olm_pkg::NUM_PTR-1:0][11:0] ptr_r,
	// Status
	output logic instrDone_r,
	output logic badOpcode_r,
	output logic destRefused_r,
	output logic secondWord_r
);

	olm_pkg::olm_phase_t phase_r;
	olm_pkg::olm_op_t op_r;
	logic [15:0] instr_r;
	logic [15:0] instr2_r;
	logic pend_r;
	logic [7:0] hold_r;
	logic [7:0] resultByte;
	logic firstWord;
	logic byteOp;
	logic destForbidden;
	logic [1:0] ptrIdx;
	olm_addr_if addrBus();

	// File address resolution
	assign addrBus.fileAddr = instr_r[7:0];
	assign addrBus.accessBit = instr_r[olm_pkg::A_BIT];
	assign addrBus.bankSel = bankSel;
	assign addrBus.extEnable = extEnable;
	assign addrBus.indexBase = ptr_r[olm_pkg::INDEX_PTR];
	olm_addr_resolve u_resolve (
		.bus(addrBus)
	);

	// Decode helpers
	assign firstWord = !pend_r && !secondWord_r;
	assign byteOp = (op_r == olm_pkg::OP_OR_FILE) || (op_r == olm_pkg::OP_COPY_DEST);
	assign ptrIdx = instr_r[5:4];
	assign destForbidden = (instr2_r[11:0] == olm_pkg::PC_LOW_ADDR) ||
		(instr2_r[11:0] == olm_pkg::STACK_TOP_LOW_ADDR) ||
		(instr2_r[11:0] == olm_pkg::STACK_TOP_HIGH_ADDR) ||
		(instr2_r[11:0] == olm_pkg::STACK_TOP_UPPER_ADDR);

	// Result of the byte operations
	always_comb begin
		unique case (op_r)
			olm_pkg::OP_OR_LIT: resultByte = acc_r | instr_r[7:0];
			olm_pkg::OP_OR_FILE: resultByte = acc_r | hold_r;
			default: resultByte = hold_r;
		endcase
	end

	// Phase sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_r <= olm_pkg::PH_Q1;
		end else begin
			unique case (phase_r)
				olm_pkg::PH_Q1: phase_r <= olm_pkg::PH_Q2;
				olm_pkg::PH_Q2: phase_r <= olm_pkg::PH_Q3;
				olm_pkg::PH_Q3: phase_r <= olm_pkg::PH_Q4;
				olm_pkg::PH_Q4: phase_r <= olm_pkg::PH_Q1;
				default: phase_r <= olm_pkg::PH_Q1;
			endcase
		end
	end

	// Instruction decode and second-word tracking
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			op_r <= olm_pkg::OP_NONE;
			instr_r <= 16'h0000;
			instr2_r <= 16'h0000;
			pend_r <= 1'b0;
			secondWord_r <= 1'b0;
			badOpcode_r <= 1'b0;
		end else begin
			badOpcode_r <= 1'b0;
			if (phase_r == olm_pkg::PH_Q1) begin
				if (pend_r) begin
					if (instrValid && instrWord[15:12] == olm_pkg::OPC_SECOND_WORD) begin
						instr2_r <= instrWord;
						secondWord_r <= 1'b1;
						pend_r <= 1'b0;
					end else if (instrValid) begin
						op_r <= olm_pkg::OP_NONE;
						badOpcode_r <= 1'b1;
						pend_r <= 1'b0;
					end
				end else begin
					secondWord_r <= 1'b0;
					instr_r <= instrWord;
					if (!instrValid) begin
						op_r <= olm_pkg::OP_NONE;
					end else if (instrWord[15:8] == olm_pkg::OPC_OR_LIT) begin
						op_r <= olm_pkg::OP_OR_LIT;
					end else if (instrWord[15:10] == olm_pkg::OPC_OR_FILE) begin
						op_r <= olm_pkg::OP_OR_FILE;
					end else if (instrWord[15:10] == olm_pkg::OPC_COPY_DEST) begin
						op_r <= olm_pkg::OP_COPY_DEST;
					end else if (instrWord[15:6] == olm_pkg::OPC_LOAD_PTR &&
						instrWord[5:4] != 2'h3) begin
						op_r <= olm_pkg::OP_LOAD_PTR;
					end else if (instrWord[15:12] == olm_pkg::OPC_FILE_TO_FILE) begin
						op_r <= olm_pkg::OP_FILE_TO_FILE;
					end else begin
						op_r <= olm_pkg::OP_NONE;
						badOpcode_r <= 1'b1;
					end
				end
			end else if (phase_r == olm_pkg::PH_Q4 && firstWord &&
				(op_r == olm_pkg::OP_LOAD_PTR || op_r == olm_pkg::OP_FILE_TO_FILE)) begin
				pend_r <= 1'b1; // Two-word forms wait for their second word
			end
		end
	end

	// Data memory reads and writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dmAddr_r <= olm_pkg::ADDR_RST;
			dmRdEn_r <= 1'b0;
			dmWrEn_r <= 1'b0;
			dmWrData_r <= 8'h00;
			destRefused_r <= 1'b0;
		end else begin
			dmRdEn_r <= 1'b0;
			dmWrEn_r <= 1'b0;
			destRefused_r <= 1'b0;
			if (phase_r == olm_pkg::PH_Q2 && firstWord) begin
				if (byteOp) begin
					dmAddr_r <= addrBus.dataAddr;
					dmRdEn_r <= 1'b1;
				end else if (op_r == olm_pkg::OP_FILE_TO_FILE &&
					instr_r[11:0] != olm_pkg::ACC_ADDR) begin
					dmAddr_r <= instr_r[11:0];
					dmRdEn_r <= 1'b1;
				end
			end
			if (phase_r == olm_pkg::PH_Q4) begin
				if (byteOp && firstWord && instr_r[olm_pkg::D_BIT] != olm_pkg::DEST_ACC) begin
					dmAddr_r <= addrBus.dataAddr; // Write back to the file
					dmWrEn_r <= 1'b1;
					dmWrData_r <= resultByte;
				end else if (op_r == olm_pkg::OP_FILE_TO_FILE && secondWord_r &&
					instr2_r[11:0] != olm_pkg::ACC_ADDR) begin
					if (destForbidden) begin
						destRefused_r <= 1'b1;
					end else begin
						dmAddr_r <= instr2_r[11:0]; // Last phase write, no read
						dmWrEn_r <= 1'b1;
						dmWrData_r <= hold_r;
					end
				end
			end
		end
	end

	// Operand capture in phase 3
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hold_r <= 8'h00;
		end else if (phase_r == olm_pkg::PH_Q3 && firstWord) begin
			if (op_r == olm_pkg::OP_FILE_TO_FILE && instr_r[11:0] == olm_pkg::ACC_ADDR) begin
				hold_r <= acc_r; // Accumulator as source
			end else if (byteOp || op_r == olm_pkg::OP_FILE_TO_FILE) begin
				hold_r <= dmRdData;
			end
		end
	end

	// Accumulator and flags
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_r <= olm_pkg::ACC_RST;
			flagN_r <= 1'b0;
			flagZ_r <= 1'b0;
		end else if (phase_r == olm_pkg::PH_Q4) begin
			if (firstWord && (op_r == olm_pkg::OP_OR_LIT || byteOp)) begin
				flagN_r <= resultByte[7];
				flagZ_r <= (resultByte == 8'h00);
				if (op_r == olm_pkg::OP_OR_LIT || instr_r[olm_pkg::D_BIT] == olm_pkg::DEST_ACC) begin
					acc_r <= resultByte;
				end
			end else if (op_r == olm_pkg::OP_FILE_TO_FILE && secondWord_r &&
				instr2_r[11:0] == olm_pkg::ACC_ADDR) begin
				acc_r <= hold_r; // Accumulator as destination
			end
		end
	end

	// Indirect pointers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_r <= {olm_pkg::NUM_PTR{olm_pkg::PTR_RST}};
		end else if (phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_LOAD_PTR) begin
			if (firstWord) begin
				ptr_r[ptrIdx][11:8] <= instr_r[3:0];
			end else if (secondWord_r) begin
				ptr_r[ptrIdx][7:0] <= instr2_r[7:0];
			end
		end
	end

	// Completion pulse after the last cycle of an instruction
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			instrDone_r <= 1'b0;
		end else begin
			instrDone_r <= (phase_r == olm_pkg::PH_Q4) &&
				((firstWord && (op_r == olm_pkg::OP_OR_LIT || byteOp)) ||
				(secondWord_r && op_r != olm_pkg::OP_NONE));
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_or_literal: assert property (
		(phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_OR_LIT && firstWord) |=>
		acc_r == ($past(acc_r) | $past(instr_r[7:0])) && instrDone_r)
		else $error("OR literal result or completion wrong");
	a_or_file_flags: assert property (
		(phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_OR_FILE && firstWord) |=>
		flagZ_r == ($past(acc_r | hold_r) == 8'h00) && flagN_r == $past(resultByte[7]))
		else $error("OR file flags wrong");
	a_dest_file: assert property (
		(phase_r == olm_pkg::PH_Q4 && byteOp && firstWord && instr_r[olm_pkg::D_BIT]) |=>
		dmWrEn_r && dmWrData_r == $past(resultByte) && $stable(acc_r))
		else $error("File destination not written");
	a_dest_acc: assert property (
		(phase_r == olm_pkg::PH_Q4 && byteOp && firstWord && !instr_r[olm_pkg::D_BIT]) |=>
		!dmWrEn_r && acc_r == $past(resultByte))
		else $error("Accumulator destination wrong");
	a_bank_address: assert property (
		(phase_r == olm_pkg::PH_Q2 && byteOp && firstWord && instr_r[olm_pkg::A_BIT]) |=>
		dmRdEn_r && dmAddr_r == {$past(bankSel), $past(instr_r[7:0])})
		else $error("Banked address wrong");
	a_indexed_address: assert property (
		(phase_r == olm_pkg::PH_Q2 && byteOp && firstWord && extEnable &&
		!instr_r[olm_pkg::A_BIT] && instr_r[7:0] <= 8'h5f) |=>
		dmAddr_r == $past(ptr_r[olm_pkg::INDEX_PTR]) + {4'h0, $past(instr_r[7:0])})
		else $error("Indexed address wrong");
	a_ptr_high_first: assert property (
		(phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_LOAD_PTR && firstWord) |=>
		ptr_r[$past(ptrIdx)][11:8] == $past(instr_r[3:0]) && pend_r && !instrDone_r)
		else $error("Pointer high bits not written after first cycle");
	a_ptr_flags_kept: assert property (
		(phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_LOAD_PTR) |=>
		$stable(flagN_r) && $stable(flagZ_r) && $stable(acc_r))
		else $error("Load pointer disturbed flags");
	a_move_no_flags: assert property (
		(phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_FILE_TO_FILE) |=>
		$stable(flagN_r) && $stable(flagZ_r))
		else $error("File-to-file move changed flags");
	a_forbidden_dest: assert property (
		(phase_r == olm_pkg::PH_Q4 && op_r == olm_pkg::OP_FILE_TO_FILE && secondWord_r) |=>
		!(dmWrEn_r && (dmAddr_r == olm_pkg::PC_LOW_ADDR ||
		dmAddr_r >= olm_pkg::STACK_TOP_LOW_ADDR)))
		else $error("Write to protected register");
	a_no_dummy_read: assert property (
		(op_r == olm_pkg::OP_FILE_TO_FILE && secondWord_r && phase_r == olm_pkg::PH_Q2) |=>
		!dmRdEn_r ##2 (dmWrEn_r || destRefused_r || acc_r == $past(hold_r, 2)))
		else $error("Second cycle read or late write");

endmodule
`default_nettype wire

// *** olm_exec_test.sv ***
// Self-checking bench for the OR / load / move execute unit.
// Drives the unit's ports directly; a byte array answers as data memory.
`timescale 1ns/100ps
`default_nettype none
module olm_exec_test;
	// Stimulus and observed signals
	logic clk_sys, rst, instrValid, extEnable;
	logic [15:0] instrWord;
	logic [3:0] bankSel;
	logic [7:0] dmRdData, acc_r, dmWrData_r;
	logic [11:0] dmAddr_r;
	logic dmRdEn_r, dmWrEn_r, flagN_r, flagZ_r, instrDone_r, badOpcode_r, destRefused_r;
	logic secondWord_r;
	logic [olm_pkg::NUM_PTR-1:0][11:0] ptr_r;
	logic [7:0] mem [0:4095];
	int miscompares = 0;
	int cmp_count = 0;
	int badSeen = 0;

	olm_exec olm_exec_i (.clk_sys(clk_sys), .rst(rst), .instrWord(instrWord),
		.instrValid(instrValid), .bankSel(bankSel), .extEnable(extEnable), .dmAddr_r(dmAddr_r),
		.dmRdEn_r(dmRdEn_r), .dmRdData(dmRdData), .dmWrEn_r(dmWrEn_r), .dmWrData_r(dmWrData_r),
		.acc_r(acc_r), .flagN_r(flagN_r), .flagZ_r(flagZ_r), .ptr_r(ptr_r),
		.instrDone_r(instrDone_r), .badOpcode_r(badOpcode_r), .destRefused_r(destRefused_r),
		.secondWord_r(secondWord_r));

	// Memory answers only while read is enabled; otherwise shows inverted data
	assign dmRdData = dmRdEn_r ? mem[dmAddr_r] : ~mem[dmAddr_r];

	// Memory write port and bad-opcode pulse counter
	always @(posedge clk_sys) begin
		if (dmWrEn_r) begin
			mem[dmAddr_r] <= dmWrData_r;
		end
		if (badOpcode_r) begin
			badSeen <= badSeen + 1;
		end
	end

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chkb(input logic g, input logic e);
		chk({11'h000, g}, {11'h000, e});
	endtask

	// Accumulator value plus sign and zero flags
	task automatic ca(input logic [7:0] e);
		chk({4'h0, acc_r}, {4'h0, e});
		chkb(flagN_r, e[7]);
		chkb(flagZ_r, e == 8'h00);
	endtask

	task automatic chkm(input logic [11:0] a, input logic [7:0] e);
		chk({4'h0, mem[a]}, {4'h0, e});
	endtask

	// One word per four-clock cycle, entered just before a phase 1 edge
	task automatic send(input logic [15:0] w);
		instrWord <= w;
		instrValid <= 1'b1;
		@(posedge clk_sys);
		instrValid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Settle just after the phase 4 edge, while completion pulses still stand
	task automatic tail;
		#1;
	endtask

	// One idle instruction cycle, ending on a phase 4 edge
	task automatic realign;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic op(input logic [15:0] w);
		send(w);
		tail();
	endtask

	task automatic t_or_lit;
		mem[12'h010] = 8'h00;
		op({olm_pkg::OPC_COPY_DEST, 2'b00, 8'h10});
		ca(8'h00);
		chkb(instrDone_r, 1'b1);
		realign();
		send({olm_pkg::OPC_OR_LIT, 8'h9a});
		op({olm_pkg::OPC_OR_LIT, 8'h35});
		ca(8'hbf);
		realign();
	endtask

	task automatic t_or_file;
		mem[12'h020] = 8'h91;
		mem[12'h010] = 8'h13;
		mem[12'h3ff] = 8'h40;
		mem[12'hf90] = 8'h04;
		bankSel <= 4'h3;
		op({olm_pkg::OPC_COPY_DEST, 2'b00, 8'h20});
		ca(8'h91);
		realign();
		op({olm_pkg::OPC_OR_FILE, 2'b00, 8'h10});
		ca(8'h93);
		realign();
		chkm(12'h010, 8'h13);
		op({olm_pkg::OPC_OR_FILE, 2'b11, 8'hff});
		chkb(flagN_r, 1'b1);
		chk({4'h0, acc_r}, 12'h093);
		realign();
		chkm(12'h3ff, 8'hd3);
		op({olm_pkg::OPC_COPY_DEST, 2'b00, 8'h90});
		ca(8'h04);
		realign();
	endtask

	// Load pointer, checking high part after cycle one and all of it after two
	task automatic lp(input logic [1:0] i, input logic [11:0] k);
		logic [11:0] old;
		logic n;
		logic z;
		old = ptr_r[i];
		n = flagN_r;
		z = flagZ_r;
		send({olm_pkg::OPC_LOAD_PTR, i, k[11:8]});
		instrWord <= {8'hf0, k[7:0]};
		instrValid <= 1'b1;
		tail();
		chk(ptr_r[i], {k[11:8], old[7:0]});
		chkb(secondWord_r, 1'b0);
		@(posedge clk_sys);
		instrValid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		tail();
		chk(ptr_r[i], k);
		chkb(instrDone_r, 1'b1);
		chkb(secondWord_r, 1'b1);
		chk({10'h000, flagN_r, flagZ_r}, {10'h000, n, z});
		realign();
	endtask

	task automatic t_indexed;
		extEnable <= 1'b1;
		lp(2'd2, 12'h300);
		mem[12'h305] = 8'h77;
		mem[12'h35f] = 8'h88;
		mem[12'h060] = 8'h11;
		mem[12'h360] = 8'hee;
		op({olm_pkg::OPC_COPY_DEST, 2'b00, 8'h05});
		ca(8'h77);
		realign();
		op({olm_pkg::OPC_COPY_DEST, 2'b00, 8'h5f});
		ca(8'h88);
		realign();
		op({olm_pkg::OPC_COPY_DEST, 2'b00, 8'h60});
		ca(8'h11);
		realign();
		extEnable <= 1'b0;
	endtask

	task automatic t_load_ptr;
		int b;
		lp(2'd0, 12'h3ab);
		lp(2'd1, 12'hfff);
		lp(2'd2, 12'h000);
		b = badSeen;
		op({olm_pkg::OPC_LOAD_PTR, 2'd3, 4'h5});
		realign();
		chk(12'(badSeen - b), 12'h001);
		chk(ptr_r[0], 12'h3ab);
	endtask

	task automatic mv(input logic [11:0] s, input logic [11:0] d);
		send({olm_pkg::OPC_FILE_TO_FILE, s});
		op({olm_pkg::OPC_SECOND_WORD, d});
	endtask

	task automatic t_file_to_file;
		logic [11:0] prot [4];
		int b;
		prot = '{olm_pkg::PC_LOW_ADDR, olm_pkg::STACK_TOP_LOW_ADDR,
			olm_pkg::STACK_TOP_HIGH_ADDR, olm_pkg::STACK_TOP_UPPER_ADDR};
		mem[12'h123] = 8'h33;
		mem[12'h456] = 8'h11;
		mv(12'h123, 12'h456);
		chk({9'h000, dmWrEn_r, flagN_r, flagZ_r}, 12'h004);
		chkb(instrDone_r, 1'b1);
		realign();
		chkm(12'h456, 8'h33);
		mv(12'h123, olm_pkg::ACC_ADDR);
		chk({4'h0, acc_r}, 12'h033);
		realign();
		mem[12'h000] = 8'h00;
		mv(olm_pkg::ACC_ADDR, 12'h000);
		realign();
		chkm(12'h000, 8'h33);
		for (int j = 0; j < 4; j++) begin
			mem[prot[j]] = 8'ha5;
			mv(12'h123, prot[j]);
			chkb(destRefused_r, 1'b1);
			chkb(dmWrEn_r, 1'b0);
			realign();
			chkm(prot[j], 8'ha5);
		end
		b = badSeen;
		send({olm_pkg::OPC_FILE_TO_FILE, 12'h010});
		op(16'h0456);
		realign();
		chk(12'(badSeen - b), 12'h001);
		chkm(12'h456, 8'h33);
	endtask

	task automatic close_out;
		$display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		instrValid = 1'b0;
		instrWord = 16'h0000;
		bankSel = 4'h0;
		extEnable = 1'b0;
		for (int a = 0; a < 4096; a++) begin
			mem[a] = a[7:0] ^ 8'h5a;
		end
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_or_lit();
		t_or_file();
		t_indexed();
		t_load_ptr();
		t_file_to_file();
		close_out();
	end

	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#50000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
